// >>> hdl/tss_top.sv
// trigger sequencer with storage qualification, post-trigger macro and axi4-lite setup
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tss_top #(
	parameter int DATA_W = 16,
	parameter int MEM_DEPTH = 1024,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [tss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [tss_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sampled target state
	input wire logic state_valid,
	input wire logic [DATA_W-1:0] state_data,
	// events
	output logic irq,
	output logic trig_pulse,
	output logic capture_full
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam int LW = tss_pkg::LV_W;
	localparam int NT = tss_pkg::N_TERMS;
	localparam int NL = tss_pkg::N_LEVELS;
	localparam int IW = tss_pkg::IRQ_W;
	localparam logic [AW:0] DEPTH_C = (AW+1)'(MEM_DEPTH);

	// bus registers
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
	logic [tss_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	// setup registers
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [NL-1:0][31:0] lcfg_r, lcfg_nxt;
	logic [NT-1:0][DATA_W-1:0] tval_r, tval_nxt, tmask_r, tmask_nxt;
	logic [NT-1:0] inv_r, inv_nxt;
	logic [IW-1:0] irq_mask_r, irq_mask_nxt;
	logic [AW-1:0] maddr_r, maddr_nxt;
	// sequencer registers
	tss_pkg::tss_run_t run_r, run_nxt;
	tss_pkg::tss_mac_t ph_r, ph_nxt;
	logic [LW-1:0] lvl_r, lvl_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [AW:0] wcnt_r, wcnt_nxt;
	logic trig_r, trig_nxt, tpulse_r, tpulse_nxt, full_r, full_nxt, irq_r, irq_nxt;
	logic [IW-1:0] istat_r, istat_nxt;

	logic wr_fire, start, mapped_w, mapped_r, mwe;
	logic [31:0] wmerged, status, rd_val;
	logic [IW-1:0] iclr, iset;
	logic [NT-1:0] hit;
	logic [DATA_W-1:0] mem_rdata;

	function automatic logic is_mapped(input logic [tss_pkg::ADDR_W-1:0] a);
		logic [2:0] bank;
		bank = a[7:5];
		is_mapped = (a[1:0] == 2'h0) && ((bank == tss_pkg::BANK_LOW && a <= tss_pkg::A_MEM_DATA) ||
			bank == tss_pkg::BANK_TVAL || bank == tss_pkg::BANK_TMASK || bank == tss_pkg::BANK_LCFG);
	endfunction

	tss_terms #(.W(DATA_W), .N(NT)) u_terms (
		.data(state_data),
		.val(tval_r),
		.mask(tmask_r),
		.inv(inv_r),
		.hit(hit)
	);

	tss_capmem #(.W(DATA_W), .DEPTH(MEM_DEPTH), .AW(AW)) u_mem (
		.aclk(aclk),
		.we(mwe),
		.waddr(wcnt_r[AW-1:0]),
		.wdata(state_data),
		.raddr(maddr_r),
		.rdata(mem_rdata)
	);

	// ---------------- axi4-lite slave ----------------
	// address and data are held separately so either may arrive first
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign mapped_w = is_mapped(awaddr_r);
	assign mapped_r = is_mapped(s_axi_araddr);
	for (genvar b = 0; b < 4; b++) begin : g_strb
		assign wmerged[8*b +: 8] = wstrb_r[b] ? wdata_r[8*b +: 8] : 8'h00;
	end

	always_comb begin
		status = '0;
		status[LW-1:0] = lvl_r;
		status[tss_pkg::S_TRIG] = trig_r;
		status[tss_pkg::S_FULL] = full_r;
		status[tss_pkg::S_RUN] = (run_r == tss_pkg::RUN_ARMED);
		status[tss_pkg::S_WCNT +: AW+1] = wcnt_r;
		rd_val = '0;
		case (s_axi_araddr[7:5])
			tss_pkg::BANK_TVAL: rd_val[DATA_W-1:0] = tval_r[s_axi_araddr[4:2]];
			tss_pkg::BANK_TMASK: rd_val[DATA_W-1:0] = tmask_r[s_axi_araddr[4:2]];
			tss_pkg::BANK_LCFG: rd_val = lcfg_r[s_axi_araddr[4:2]];
			default: begin
				case (s_axi_araddr)
					tss_pkg::A_CTRL: rd_val = ctrl_r;
					tss_pkg::A_STATUS: rd_val = status;
					tss_pkg::A_IRQ_STAT: rd_val[IW-1:0] = istat_r;
					tss_pkg::A_IRQ_MASK: rd_val[IW-1:0] = irq_mask_r;
					tss_pkg::A_TERM_INV: rd_val[NT-1:0] = inv_r;
					tss_pkg::A_MEM_ADDR: rd_val[AW-1:0] = maddr_r;
					tss_pkg::A_MEM_DATA: rd_val[DATA_W-1:0] = mem_rdata;
					default: rd_val = '0;
				endcase
			end
		endcase
	end

	always_comb begin
		aw_held_nxt = aw_held_r;
		awaddr_nxt = awaddr_r;
		w_held_nxt = w_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && !aw_held_r && !bvalid_r) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_r && !bvalid_r) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = mapped_w ? tss_pkg::RESP_OKAY : tss_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_val;
			rresp_nxt = mapped_r ? tss_pkg::RESP_OKAY : tss_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		// readies come from flops holding what the held flags will be, so timing matches the flags
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt = !w_held_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
			w_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= tss_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= tss_pkg::RESP_OKAY;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			aw_held_r <= aw_held_nxt;
			awaddr_r <= awaddr_nxt;
			w_held_r <= w_held_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ---------------- setup registers ----------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		lcfg_nxt = lcfg_r;
		tval_nxt = tval_r;
		tmask_nxt = tmask_r;
		inv_nxt = inv_r;
		irq_mask_nxt = irq_mask_r;
		maddr_nxt = maddr_r;
		start = 1'b0;
		iclr = '0;
		if (wr_fire && mapped_w) begin
			case (awaddr_r[7:5])
				tss_pkg::BANK_TVAL: tval_nxt[awaddr_r[4:2]] = wmerged[DATA_W-1:0];
				tss_pkg::BANK_TMASK: tmask_nxt[awaddr_r[4:2]] = wmerged[DATA_W-1:0];
				tss_pkg::BANK_LCFG: lcfg_nxt[awaddr_r[4:2]] = wmerged;
				default: begin
					case (awaddr_r)
						tss_pkg::A_CTRL: begin
							// start is a strobe, never kept in the register
							ctrl_nxt = wmerged & ~(32'h0000_0001 << tss_pkg::C_START);
							start = wmerged[tss_pkg::C_START];
						end
						tss_pkg::A_IRQ_STAT: iclr = wmerged[IW-1:0];
						tss_pkg::A_IRQ_MASK: irq_mask_nxt = wmerged[IW-1:0];
						tss_pkg::A_TERM_INV: inv_nxt = wmerged[NT-1:0];
						tss_pkg::A_MEM_ADDR: maddr_nxt = wmerged[AW-1:0];
						default: ;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= tss_pkg::CTRL_RST;
			lcfg_r <= {NL{tss_pkg::LCFG_RST}};
			tval_r <= '0;
			tmask_r <= '0;
			inv_r <= '0;
			irq_mask_r <= '0;
			maddr_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			lcfg_r <= lcfg_nxt;
			tval_r <= tval_nxt;
			tmask_r <= tmask_nxt;
			inv_r <= inv_nxt;
			irq_mask_r <= irq_mask_nxt;
			maddr_r <= maddr_nxt;
		end
	end

	// ---------------- sequencer ----------------
	logic [LW-1:0] last_raw, trig_raw, last_lv, trig_lv, sec_tgt;
	logic [31:0] cfg;
	logic [CNT_W-1:0] need;
	logic macro_lv, sec_ok;
	assign last_raw = ctrl_r[tss_pkg::C_LAST +: LW];
	assign trig_raw = ctrl_r[tss_pkg::C_TRIG +: LW];
	assign last_lv = (last_raw == '0) ? LW'(1) : last_raw;
	assign trig_lv = (trig_raw >= last_lv) ? last_lv - LW'(1) : trig_raw;
	assign cfg = lcfg_r[lvl_r];
	assign need = (cfg[tss_pkg::L_COUNT +: CNT_W] == '0) ? CNT_W'(1) : cfg[tss_pkg::L_COUNT +: CNT_W];
	assign sec_tgt = cfg[tss_pkg::L_SEC_TGT +: LW];
	assign sec_ok = ((sec_tgt <= trig_lv) == (lvl_r <= trig_lv)) && (sec_tgt <= last_lv);
	// the macro must lie after the trigger, otherwise it would swallow it
	assign macro_lv = ctrl_r[tss_pkg::C_MACRO] && (lvl_r == last_lv - LW'(1)) && (trig_lv < lvl_r);

	always_comb begin
		run_nxt = run_r;
		ph_nxt = ph_r;
		lvl_nxt = lvl_r;
		cnt_nxt = cnt_r;
		wcnt_nxt = wcnt_r;
		trig_nxt = trig_r;
		full_nxt = full_r;
		tpulse_nxt = 1'b0;
		mwe = 1'b0;
		iset = '0;
		if (start) begin
			run_nxt = tss_pkg::RUN_ARMED;
			ph_nxt = tss_pkg::MAC_SEEK;
			lvl_nxt = '0;
			cnt_nxt = '0;
			wcnt_nxt = '0;
			trig_nxt = 1'b0;
			full_nxt = 1'b0;
		end else if (run_r == tss_pkg::RUN_ARMED && state_valid) begin
			if (macro_lv) begin
				if (ph_r == tss_pkg::MAC_SEEK) begin
					mwe = hit[cfg[tss_pkg::L_STORE +: LW]];
					if (hit[ctrl_r[tss_pkg::C_EN_TERM +: LW]]) begin
						ph_nxt = tss_pkg::MAC_STORE;
					end
				end else begin
					mwe = hit[ctrl_r[tss_pkg::C_MS_TERM +: LW]];
					if (hit[ctrl_r[tss_pkg::C_DIS_TERM +: LW]]) begin
						ph_nxt = tss_pkg::MAC_SEEK;
					end
				end
			end else begin
				mwe = hit[cfg[tss_pkg::L_STORE +: LW]];
				if (lvl_r != last_lv && hit[cfg[tss_pkg::L_PRIM +: LW]]) begin
					if ({1'b0, cnt_r} + (CNT_W+1)'(1) >= {1'b0, need}) begin
						lvl_nxt = lvl_r + LW'(1);
						if (lvl_r == trig_lv) begin
							trig_nxt = 1'b1;
							tpulse_nxt = 1'b1;
							iset[tss_pkg::I_TRIG] = 1'b1;
							mwe = 1'b1;
						end
					end else begin
						cnt_nxt = cnt_r + CNT_W'(1);
					end
				end else if (cfg[tss_pkg::L_SEC_EN] && hit[cfg[tss_pkg::L_SEC_TERM +: LW]] && sec_ok) begin
					lvl_nxt = sec_tgt;
				end else if (ctrl_r[tss_pkg::C_RESTART] && lvl_r <= trig_lv &&
					hit[ctrl_r[tss_pkg::C_RS_TERM +: LW]]) begin
					lvl_nxt = '0;
				end
				if (lvl_nxt != lvl_r) begin
					cnt_nxt = '0;
					iset[tss_pkg::I_LEVEL] = 1'b1;
				end
			end
			if (mwe) begin
				wcnt_nxt = wcnt_r + (AW+1)'(1);
				if (wcnt_nxt == DEPTH_C) begin
					run_nxt = tss_pkg::RUN_DONE;
					full_nxt = 1'b1;
					iset[tss_pkg::I_FULL] = 1'b1;
				end
			end
		end
		// a new event beats a clear in the same cycle
		istat_nxt = (istat_r & ~iclr) | iset;
		irq_nxt = |(istat_r & irq_mask_r);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= tss_pkg::RUN_IDLE;
			ph_r <= tss_pkg::MAC_SEEK;
			lvl_r <= '0;
			cnt_r <= '0;
			wcnt_r <= '0;
			trig_r <= 1'b0;
			full_r <= 1'b0;
			tpulse_r <= 1'b0;
			istat_r <= '0;
			irq_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			ph_r <= ph_nxt;
			lvl_r <= lvl_nxt;
			cnt_r <= cnt_nxt;
			wcnt_r <= wcnt_nxt;
			trig_r <= trig_nxt;
			full_r <= full_nxt;
			tpulse_r <= tpulse_nxt;
			istat_r <= istat_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign irq = irq_r;
	assign trig_pulse = tpulse_r;
	assign capture_full = full_r;
endmodule // tss_top
`default_nettype wire

// >>> shared/tss_pkg.sv
// shared constants, register map and state types of the trigger sequencer
package tss_pkg;
	localparam int N_LEVELS = 8;
	localparam int N_TERMS = 8;
	localparam int LV_W = 3;
	localparam int ADDR_W = 8;
	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_IRQ_STAT = 8'h08;
	localparam logic [7:0] A_IRQ_MASK = 8'h0C;
	localparam logic [7:0] A_TERM_INV = 8'h10;
	localparam logic [7:0] A_MEM_ADDR = 8'h14;
	localparam logic [7:0] A_MEM_DATA = 8'h18;
	// per-entry banks, index in bits [4:2], bank in bits [7:5]
	localparam logic [2:0] BANK_LOW = 3'h0;
	localparam logic [2:0] BANK_TVAL = 3'h2;
	localparam logic [2:0] BANK_TMASK = 3'h3;
	localparam logic [2:0] BANK_LCFG = 3'h4;
	// control fields
	localparam int C_START = 0;
	localparam int C_RESTART = 1;
	localparam int C_MACRO = 2;
	localparam int C_LAST = 4;
	localparam int C_TRIG = 8;
	localparam int C_RS_TERM = 12;
	localparam int C_EN_TERM = 16;
	localparam int C_MS_TERM = 20;
	localparam int C_DIS_TERM = 24;
	localparam logic [31:0] CTRL_RST = 32'h0000_0010;
	// level configuration fields
	localparam int L_STORE = 0;
	localparam int L_PRIM = 4;
	localparam int L_SEC_TGT = 8;
	localparam int L_SEC_TERM = 12;
	localparam int L_SEC_EN = 15;
	localparam int L_COUNT = 16;
	localparam logic [31:0] LCFG_RST = 32'h0001_0000;
	// status fields
	localparam int S_TRIG = 4;
	localparam int S_FULL = 5;
	localparam int S_RUN = 6;
	localparam int S_WCNT = 16;
	// interrupt bits
	localparam int I_TRIG = 0;
	localparam int I_FULL = 1;
	localparam int I_LEVEL = 2;
	localparam int IRQ_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {RUN_IDLE = 2'h0, RUN_ARMED = 2'h1, RUN_DONE = 2'h3} tss_run_t;
	typedef enum logic [0:0] {MAC_SEEK = 1'h0, MAC_STORE = 1'h1} tss_mac_t;
endpackage

// >>> hdl/tss_terms.sv
// bank of qualifier terms matched against one sampled state
`timescale 1ns/1ps
`default_nettype none
module tss_terms #(
	parameter int W = 16,
	parameter int N = 8
) (
	// sampled state
	input wire logic [W-1:0] data,
	// term setup
	input wire logic [N-1:0][W-1:0] val,
	input wire logic [N-1:0][W-1:0] mask,
	input wire logic [N-1:0] inv,
	// result
	output logic [N-1:0] hit
);
	// mask bit 0 is a don't-care, so mask 0 is any state and mask 0 inverted is no state
	for (genvar i = 0; i < N; i++) begin : g_term
		assign hit[i] = (((data ^ val[i]) & mask[i]) == '0) ^ inv[i];
	end
endmodule // tss_terms
`default_nettype wire

// >>> hdl/tss_capmem.sv
// flip-flop capture memory, one write port and one combinational read port
`timescale 1ns/1ps
`default_nettype none
module tss_capmem #(
	parameter int W = 16,
	parameter int DEPTH = 1024,
	parameter int AW = $clog2(DEPTH)
) (
	// clock
	input wire logic aclk,
	// write
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	assign rdata = mem[raddr];
endmodule // tss_capmem
`default_nettype wire

// >>> test/tss_top_sva.sv
// port assertions for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module tss_top_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// stream and events
	input wire logic state_valid,
	input wire logic trig_pulse,
	input wire logic capture_full
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken while answer pending");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write answer late");
	property p_trig_one;
		trig_pulse |=> !trig_pulse;
	endproperty
	a_trig_one: assert property (p_trig_one) else $error("trigger pulse too long");
	property p_trig_cause;
		trig_pulse |-> $past(state_valid);
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("trigger without a state");
	property p_full_hold;
		capture_full && !s_axi_awvalid && !s_axi_wvalid && s_axi_awready && s_axi_wready |=> capture_full;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full flag lost");
	property p_full_cause;
		$rose(capture_full) |-> $past(state_valid);
	endproperty
	a_full_cause: assert property (p_full_cause) else $error("full without a store");
	c_trig: cover property (trig_pulse);
	c_full: cover property ($rose(capture_full));
	c_err: cover property (s_axi_bvalid && s_axi_bresp == tss_pkg::RESP_SLVERR);
endmodule // tss_top_sva
`default_nettype wire

// >>> test/tss_src.sv
// sampled state source standing in for the target system
`timescale 1ns/1ps
`default_nettype none
module tss_src #(
	parameter int W = 16
) (
	// clock
	input wire logic aclk,
	// state stream
	output logic state_valid,
	output logic [W-1:0] state_data
);
	initial begin
		state_valid = 1'h0;
		state_data = '0;
	end
	// idle cycles show the inverse of the last state so stale data never looks valid
	task automatic burst(input logic [W-1:0] q[$], input logic gap);
		foreach (q[i]) begin
			state_valid <= 1'h1;
			state_data <= q[i];
			@(posedge aclk);
			if (gap) begin
				state_valid <= 1'h0;
				state_data <= ~q[i];
				@(posedge aclk);
			end
		end
		state_valid <= 1'h0;
		state_data <= ~q[q.size()-1];
		@(posedge aclk);
	endtask
endmodule // tss_src
`default_nettype wire

// >>> test/tss_top_bench.sv
// self-checking bench of the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module tss_top_bench;
	localparam logic [15:0] VA = 16'hb03c;
	localparam logic [15:0] VB = 16'h0000;
	localparam logic [15:0] VC = 16'h8930;
	localparam logic [1:0] OK = tss_pkg::RESP_OKAY;
	localparam logic [15:0] TV [3] = '{VA, VB, VC};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq, trig_pulse, capture_full, state_valid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] state_data;
	int bad_count = 0, samples_checked = 0, trig_seen = 0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (trig_pulse === 1'h1) trig_seen++;
	tss_top #(.MEM_DEPTH(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.state_valid(state_valid), .state_data(state_data), .irq(irq), .trig_pulse(trig_pulse),
		.capture_full(capture_full));
	tss_src #(.W(16)) SRC (.aclk(aclk), .state_valid(state_valid), .state_data(state_data));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready === 1'h1)
				awvalid <= 1'h0;
			if (wready === 1'h1)
				wvalid <= 1'h0;
			ta = ta | (awready === 1'h1);
			tw = tw | (wready === 1'h1);
		end
		do
			@(posedge aclk);
		while (bvalid !== 1'h1);
		chk(bresp, er);
		bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
			@(posedge aclk);
		while (arready !== 1'h1);
		arvalid <= 1'h0;
		do
			@(posedge aclk);
		while (rvalid !== 1'h1);
		d = rdata;
		chk(rresp, er);
		rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, OK, d);
		chk(d & m, e);
	endtask
	task automatic mc(input int i, input logic [15:0] e);
		wr(tss_pkg::A_MEM_ADDR, 32'(i), OK);
		rc(tss_pkg::A_MEM_DATA, 32'h0000_ffff, {16'h0000, e});
	endtask
	function automatic logic [31:0] lv(input logic [2:0] st, pr, tg, se, input logic en, input logic [15:0] n);
		return {n, en, se, 1'h0, tg, 1'h0, pr, 1'h0, st};
	endfunction
	function automatic logic [31:0] cf(input logic [2:0] la, tr, rs, en, ms, ds, fl);
		return {5'h00, ds, 1'h0, ms, 1'h0, en, 1'h0, rs, 1'h0, tr, 1'h0, la, 1'h0, fl};
	endfunction
	// reset and program terms 0..2 to exact states, term 3 to no state, term 7 stays any state
	task automatic setup();
		aresetn <= 1'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		trig_seen = 0;
		@(posedge aclk);
		for (int i = 0; i < 3; i++) begin
			wr(8'h40 + 8'(i * 4), {16'h0000, TV[i]}, OK);
			wr(8'h60 + 8'(i * 4), 32'h0000_ffff, OK);
		end
		wr(tss_pkg::A_TERM_INV, 32'h0000_0008, OK);
	endtask
	task automatic t_regs();
		logic [31:0] d;
		setup();
		rc(tss_pkg::A_CTRL, 32'hffff_ffff, tss_pkg::CTRL_RST);
		rc(8'h80, 32'hffff_ffff, tss_pkg::LCFG_RST);
		rc(8'h9c, 32'hffff_ffff, tss_pkg::LCFG_RST);
		rd(8'h1c, tss_pkg::RESP_SLVERR, d);
		wr(8'h1c, 32'h0000_0001, tss_pkg::RESP_SLVERR);
		// lanes without strobe are written as zero, not kept
		wstrb <= 4'h3;
		wr(8'h84, 32'h1234_5678, OK);
		wstrb <= 4'hf;
		rc(8'h84, 32'hffff_ffff, 32'h0000_5678);
		$display("test regs done");
	endtask
	task automatic t_trig();
		setup();
		wr(tss_pkg::A_IRQ_MASK, 32'h0000_0001, OK);
		wr(8'h80, lv(7, 0, 0, 0, 0, 2), OK);
		wr(8'h84, lv(1, 2, 0, 0, 0, 1), OK);
		wr(8'h88, lv(3, 0, 0, 0, 0, 1), OK);
		wr(tss_pkg::A_CTRL, cf(2, 1, 0, 0, 0, 0, 3'h1), OK);
		SRC.burst('{16'h1234, VA, VA, 16'h5678, VB, VC, VB, VA}, 1'h1);
		rc(tss_pkg::A_STATUS, 32'hffff_0037, 32'h0005_0012);
		chk(trig_seen, 32'h0000_0001);
		chk(irq, 1'h1);
		mc(0, 16'h1234);
		mc(3, VB);
		mc(4, VC);
		wr(tss_pkg::A_IRQ_STAT, 32'h0000_0001, OK);
		repeat (2) @(posedge aclk);
		chk(irq, 1'h0);
		$display("test trigger done");
	endtask
	task automatic t_sec();
		setup();
		wr(8'h80, lv(7, 0, 2, 1, 1, 3), OK);
		wr(tss_pkg::A_CTRL, cf(3, 2, 0, 0, 0, 0, 3'h1), OK);
		SRC.burst('{VA, VB}, 1'h0);
		rc(tss_pkg::A_STATUS, 32'hffff_0017, 32'h0002_0002);
		wr(8'h80, lv(7, 0, 3, 1, 1, 3), OK);
		wr(tss_pkg::A_CTRL, cf(3, 2, 0, 0, 0, 0, 3'h1), OK);
		SRC.burst('{VA, VB}, 1'h0);
		rc(tss_pkg::A_STATUS, 32'hffff_0017, 32'h0002_0000);
		$display("test secondary done");
	endtask
	task automatic t_rst();
		setup();
		wr(8'h80, lv(7, 0, 0, 0, 0, 1), OK);
		wr(8'h84, lv(7, 2, 0, 0, 0, 2), OK);
		wr(tss_pkg::A_CTRL, cf(3, 2, 1, 0, 0, 0, 3'h3), OK);
		SRC.burst('{VA, VC, VB, VA, VC}, 1'h0);
		rc(tss_pkg::A_STATUS, 32'hffff_0007, 32'h0005_0001);
		SRC.burst('{VC}, 1'h0);
		rc(tss_pkg::A_STATUS, 32'hffff_0007, 32'h0006_0002);
		$display("test restart done");
	endtask
	task automatic t_mac();
		setup();
		wr(8'h80, lv(3, 0, 0, 0, 0, 1), OK);
		wr(8'h84, lv(1, 0, 0, 0, 0, 1), OK);
		wr(tss_pkg::A_CTRL, cf(2, 0, 0, 2, 0, 1, 3'h5), OK);
		SRC.burst('{VA, VB, VA, VC, VA, VB, VA, VB, VC, VA, VA, VB, VC, VA, VA, VA, VB}, 1'h0);
		chk(capture_full, 1'h1);
		rc(tss_pkg::A_STATUS, 32'hffff_0030, 32'h0008_0030);
		mc(0, VA);
		mc(1, VB);
		mc(2, VA);
		mc(3, VB);
		mc(7, VA);
		$display("test macro done");
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		t_regs();
		t_trig();
		t_sec();
		t_rst();
		t_mac();
		results();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		results();
	end
endmodule // tss_top_bench
bind tss_top tss_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .state_valid, .trig_pulse, .capture_full);
`default_nettype wire
